// ### hw/tuner_serial_pkg.sv
package tuner_serial_pkg;

  // Register offsets as seen over the serial link.
  localparam logic [7:0] ADDR_FILTER_CAP = 8'h08;
  localparam logic [7:0] ADDR_ROM_SELECT = 8'h09;
  localparam logic [7:0] ADDR_RESERVED = 8'h0a;
  localparam logic [7:0] ADDR_ROM_READBACK = 8'h0b;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // Field positions inside the registers.
  localparam int FLD_BIT = 7;
  localparam int CAP_CODE_MSB = 5;
  localparam int INDEX_MSB = 3;
  localparam int POR_BIT = 7;

  // Reset values of the stored fields.
  localparam logic [5:0] CAP_CODE_RESET = 6'h00;
  localparam logic [3:0] INDEX_RESET = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] STATUS_LOW_ZERO = 4'h0;

  // Fixed upper part of the seven-bit slave address.
  localparam logic [4:0] SLAVE_ADDR_PREFIX = 5'h18;

  // Bit counting within a byte.
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // Bus clock ceiling and the sampling clocks that must outrun it.
  localparam int SCL_MAX_KHZ = 400;
  localparam int SYS_CLK_KHZ = 50000;

  // Link engine states.
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WDATA,
    ST_WDATA_ACK, ST_RWAIT, ST_RDATA, ST_RDATA_ACK, ST_RACK_OK
  } link_state_t;

endpackage

// ### hw/tuner_serial_control_slave.sv
`timescale 1ns/1ps
module tuner_serial_control_slave #(
  // Factory ROM contents, entry n in bits 8n+7..8n; arbitrary default.
  parameter logic [127:0] FACTORY_ROM = 128'h0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_link,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic i_addr_strap_high,
  input wire logic i_addr_strap_low,
  input wire logic [2:0] i_lock_indicator,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [5:0] o_parallel_cap_code
);

  // ---------------- Link clock domain ----------------

  logic link_rst_meta_r; // First stage of the reset synchroniser.
  logic link_rst_n_r; // Reset as seen by the link domain.
  logic scl_meta_r; // First stage of the clock line synchroniser.
  logic scl_s_r; // Synchronised clock line.
  logic scl_d_r; // Clock line one sample later.
  logic sda_meta_r; // First stage of the data line synchroniser.
  logic sda_s_r; // Synchronised data line.
  logic sda_d_r; // Data line one sample later.
  logic strap_hi_meta_r; // First stage of the high strap synchroniser.
  logic strap_hi_r; // Synchronised high strap.
  logic strap_lo_meta_r; // First stage of the low strap synchroniser.
  logic strap_lo_r; // Synchronised low strap.
  logic start_det; // Start condition seen this sample.
  logic stop_det; // Stop condition seen this sample.
  logic scl_rise; // Clock line rising edge.
  logic scl_fall; // Clock line falling edge.
  logic [6:0] own_addr; // Seven-bit slave address from straps.
  tuner_serial_pkg::link_state_t state_r; // Engine state.
  logic [3:0] bit_cnt_r; // Bits moved in the current byte.
  logic [7:0] shift_r; // Receive shift register.
  logic [7:0] tx_r; // Transmit shift register.
  logic rw_r; // Direction bit of the last matching address.
  logic [7:0] ptr_r; // Register pointer.
  logic sda_oe_r; // Data line pull-down enable.
  logic sda_out_r; // Level driven while enabled, always low.
  logic req_tgl_r; // Toggles once per register access request.
  logic req_we_r; // Request is a write.
  logic [7:0] req_addr_r; // Register addressed by the request.
  logic [7:0] req_wdata_r; // Data carried by a write request.
  logic ack_meta_r; // First stage of the answer toggle synchroniser.
  logic ack_s_r; // Synchronised answer toggle.
  logic ack_d_r; // Answer toggle one sample later.
  logic ack_edge; // Sys domain has answered a request.
  logic ack_tgl_r; // Toggles once per finished access, sys domain.
  logic [7:0] rdata_r; // Read answer, stable until the next request.

  // The reset is brought into the link domain by two flip-flops.
  always_ff @(posedge i_clk_link) begin
    link_rst_meta_r <= i_rst_n;
    link_rst_n_r <= link_rst_meta_r;
  end

  // Bus lines and straps come from outside and pass two flip-flops.
  always_ff @(posedge i_clk_link) begin
    if (!link_rst_n_r) begin
      scl_meta_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      strap_hi_meta_r <= 1'b0;
      strap_hi_r <= 1'b0;
      strap_lo_meta_r <= 1'b0;
      strap_lo_r <= 1'b0;
    end else begin
      scl_meta_r <= i_scl;
      scl_s_r <= scl_meta_r;
      scl_d_r <= scl_s_r;
      sda_meta_r <= i_sda_in;
      sda_s_r <= sda_meta_r;
      sda_d_r <= sda_s_r;
      strap_hi_meta_r <= i_addr_strap_high;
      strap_hi_r <= strap_hi_meta_r;
      strap_lo_meta_r <= i_addr_strap_low;
      strap_lo_r <= strap_lo_meta_r;
    end
  end

  // A data change while the clock stays high is a start or a stop.
  assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  // The master owns the clock; edges are taken from its line.
  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  // The address is the fixed prefix followed by the straps, high first.
  assign own_addr = {tuner_serial_pkg::SLAVE_ADDR_PREFIX,
                     strap_hi_r, strap_lo_r};

  // The answer toggle from the sys domain is synchronised here.
  always_ff @(posedge i_clk_link) begin
    if (!link_rst_n_r) begin
      ack_meta_r <= 1'b0;
      ack_s_r <= 1'b0;
      ack_d_r <= 1'b0;
    end else begin
      ack_meta_r <= ack_tgl_r;
      ack_s_r <= ack_meta_r;
      ack_d_r <= ack_s_r;
    end
  end

  // Each change of the synchronised toggle marks one finished access.
  assign ack_edge = ack_s_r ^ ack_d_r;

  // The byte engine: addressing, pointer, data and acknowledge slots.
  always_ff @(posedge i_clk_link) begin
    if (!link_rst_n_r) begin
      state_r <= tuner_serial_pkg::ST_IDLE;
      bit_cnt_r <= tuner_serial_pkg::BIT_ZERO;
      shift_r <= tuner_serial_pkg::BYTE_ZERO;
      tx_r <= tuner_serial_pkg::BYTE_ZERO;
      rw_r <= 1'b0;
      ptr_r <= tuner_serial_pkg::BYTE_ZERO;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
      req_tgl_r <= 1'b0;
      req_we_r <= 1'b0;
      req_addr_r <= tuner_serial_pkg::BYTE_ZERO;
      req_wdata_r <= tuner_serial_pkg::BYTE_ZERO;
    end else if (start_det) begin
      // A start, repeated or not, always begins a new address byte.
      state_r <= tuner_serial_pkg::ST_ADDR;
      bit_cnt_r <= tuner_serial_pkg::BIT_ZERO;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      // A stop closes any transfer; the line is let go.
      state_r <= tuner_serial_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      // Received bits are sampled on the rising clock edge, MSB first.
      if (scl_rise && bit_cnt_r != tuner_serial_pkg::BYTE_BITS &&
          (state_r == tuner_serial_pkg::ST_ADDR ||
           state_r == tuner_serial_pkg::ST_REG ||
           state_r == tuner_serial_pkg::ST_WDATA)) begin
        shift_r <= {shift_r[6:0], sda_s_r};
        bit_cnt_r <= bit_cnt_r + tuner_serial_pkg::BIT_ONE;
      end
      case (state_r)
        tuner_serial_pkg::ST_IDLE: begin
          // Nothing moves until the next start.
          sda_oe_r <= 1'b0;
        end
        tuner_serial_pkg::ST_ADDR: begin
          if (scl_fall && bit_cnt_r == tuner_serial_pkg::BYTE_BITS) begin
            if (shift_r[7:1] == own_addr) begin
              // Our address: pull the line low for the ninth clock.
              sda_oe_r <= 1'b1;
              rw_r <= shift_r[0];
              state_r <= tuner_serial_pkg::ST_ADDR_ACK;
            end else begin
              // Someone else's address: stay released until a start.
              state_r <= tuner_serial_pkg::ST_IDLE;
            end
          end
        end
        tuner_serial_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            bit_cnt_r <= tuner_serial_pkg::BIT_ZERO;
            if (rw_r) begin
              // Read: fetch the register at the pointer.
              req_tgl_r <= ~req_tgl_r;
              req_we_r <= 1'b0;
              req_addr_r <= ptr_r;
              state_r <= tuner_serial_pkg::ST_RWAIT;
            end else begin
              // Write: the next byte is the register address.
              state_r <= tuner_serial_pkg::ST_REG;
            end
          end
        end
        tuner_serial_pkg::ST_REG: begin
          if (scl_fall && bit_cnt_r == tuner_serial_pkg::BYTE_BITS) begin
            ptr_r <= shift_r;
            sda_oe_r <= 1'b1;
            state_r <= tuner_serial_pkg::ST_REG_ACK;
          end
        end
        tuner_serial_pkg::ST_REG_ACK: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            bit_cnt_r <= tuner_serial_pkg::BIT_ZERO;
            state_r <= tuner_serial_pkg::ST_WDATA;
          end
        end
        tuner_serial_pkg::ST_WDATA: begin
          if (scl_fall && bit_cnt_r == tuner_serial_pkg::BYTE_BITS) begin
            // Hand the byte over and acknowledge it.
            req_tgl_r <= ~req_tgl_r;
            req_we_r <= 1'b1;
            req_addr_r <= ptr_r;
            req_wdata_r <= shift_r;
            ptr_r <= ptr_r + tuner_serial_pkg::PTR_STEP;
            sda_oe_r <= 1'b1;
            state_r <= tuner_serial_pkg::ST_WDATA_ACK;
          end
        end
        tuner_serial_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            // Stay open for any number of further bytes.
            sda_oe_r <= 1'b0;
            bit_cnt_r <= tuner_serial_pkg::BIT_ZERO;
            state_r <= tuner_serial_pkg::ST_WDATA;
          end
        end
        tuner_serial_pkg::ST_RWAIT: begin
          if (ack_edge) begin
            // Present the MSB while the clock is still low.
            tx_r <= rdata_r;
            sda_oe_r <= ~rdata_r[7];
            bit_cnt_r <= tuner_serial_pkg::BIT_ZERO;
            ptr_r <= ptr_r + tuner_serial_pkg::PTR_STEP;
            state_r <= tuner_serial_pkg::ST_RDATA;
          end
        end
        tuner_serial_pkg::ST_RDATA: begin
          if (scl_fall) begin
            bit_cnt_r <= bit_cnt_r + tuner_serial_pkg::BIT_ONE;
            if (bit_cnt_r == tuner_serial_pkg::LAST_TX_BIT) begin
              // Release for the master's acknowledge slot.
              sda_oe_r <= 1'b0;
              state_r <= tuner_serial_pkg::ST_RDATA_ACK;
            end else begin
              sda_oe_r <= ~tx_r[6];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          end
        end
        tuner_serial_pkg::ST_RDATA_ACK: begin
          if (scl_rise) begin
            // Low means go on; high ends the read until stop or start.
            if (!sda_s_r) begin
              state_r <= tuner_serial_pkg::ST_RACK_OK;
            end else begin
              state_r <= tuner_serial_pkg::ST_IDLE;
            end
          end
        end
        tuner_serial_pkg::ST_RACK_OK: begin
          if (scl_fall) begin
            // Fetch the next successive register.
            req_tgl_r <= ~req_tgl_r;
            req_we_r <= 1'b0;
            req_addr_r <= ptr_r;
            state_r <= tuner_serial_pkg::ST_RWAIT;
          end
        end
        default: begin
          state_r <= tuner_serial_pkg::ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // The pin is driven straight from the engine flip-flops.
  assign o_sda_oe = sda_oe_r;
  assign o_sda_out = sda_out_r;

  // ---------------- System clock domain ----------------

  logic req_meta_r; // First stage of the request toggle synchroniser.
  logic req_s_r; // Synchronised request toggle.
  logic req_d_r; // Request toggle one sample later.
  logic req_edge; // A new request is waiting.
  logic [5:0] cap_code_r; // Parallel capacitor code.
  logic fld_r; // Stored filter load strobe.
  logic [3:0] index_r; // Selected ROM entry.
  logic [7:0] readback_r; // Loaded ROM entry.
  logic por_r; // Power-on flag.
  logic [2:0] lock_meta_r; // First stage of the lock synchroniser.
  logic [2:0] lock_r; // Synchronised lock indicator.
  logic wr_cap; // Write to the parallel capacitor register.
  logic rd_status; // Read of the status register.
  logic [7:0] rd_mux; // Register value selected by the request.

  // Request toggle and lock inputs cross by two flip-flops each.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      req_meta_r <= 1'b0;
      req_s_r <= 1'b0;
      req_d_r <= 1'b0;
      lock_meta_r <= 3'h0;
      lock_r <= 3'h0;
    end else begin
      req_meta_r <= req_tgl_r;
      req_s_r <= req_meta_r;
      req_d_r <= req_s_r;
      lock_meta_r <= i_lock_indicator;
      lock_r <= lock_meta_r;
    end
  end

  // Request fields are held stable by the link side until answered.
  assign req_edge = req_s_r ^ req_d_r;
  assign wr_cap = req_edge & req_we_r &
                  (req_addr_r == tuner_serial_pkg::ADDR_FILTER_CAP);
  assign rd_status = req_edge & ~req_we_r &
                     (req_addr_r == tuner_serial_pkg::ADDR_STATUS);

  // Read selection; unmapped registers, the reserved slot included, read 0.
  always_comb begin
    rd_mux = tuner_serial_pkg::BYTE_ZERO;
    case (req_addr_r)
      tuner_serial_pkg::ADDR_FILTER_CAP: begin
        rd_mux = {fld_r, 1'b0, cap_code_r};
      end
      tuner_serial_pkg::ADDR_ROM_SELECT: begin
        rd_mux = {4'h0, index_r};
      end
      tuner_serial_pkg::ADDR_ROM_READBACK: begin
        rd_mux = readback_r;
      end
      tuner_serial_pkg::ADDR_STATUS: begin
        rd_mux = {por_r, lock_r, tuner_serial_pkg::STATUS_LOW_ZERO};
      end
      default: begin
        rd_mux = tuner_serial_pkg::BYTE_ZERO;
      end
    endcase
  end

  // Each request is answered with a toggle and, for reads, the data.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ack_tgl_r <= 1'b0;
      rdata_r <= tuner_serial_pkg::BYTE_ZERO;
    end else if (req_edge) begin
      ack_tgl_r <= ~ack_tgl_r;
      if (!req_we_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Parallel capacitor register; the reserved bit is never stored.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cap_code_r <= tuner_serial_pkg::CAP_CODE_RESET;
      fld_r <= 1'b0;
    end else if (wr_cap) begin
      cap_code_r <= req_wdata_r[tuner_serial_pkg::CAP_CODE_MSB:0];
      fld_r <= req_wdata_r[tuner_serial_pkg::FLD_BIT];
    end
  end

  // The capacitor code drives the tracking filter from a flip-flop.
  assign o_parallel_cap_code = cap_code_r;

  // ROM entry select; the reserved writes to the slot are dropped.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      index_r <= tuner_serial_pkg::INDEX_RESET;
    end else if (req_edge && req_we_r &&
                 req_addr_r == tuner_serial_pkg::ADDR_ROM_SELECT) begin
      index_r <= req_wdata_r[tuner_serial_pkg::INDEX_MSB:0];
    end
  end

  // A 0 to 1 write of the strobe copies the selected ROM entry.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      readback_r <= tuner_serial_pkg::BYTE_ZERO;
    end else if (wr_cap && req_wdata_r[tuner_serial_pkg::FLD_BIT] &&
                 !fld_r) begin
      readback_r <= FACTORY_ROM[{index_r, 3'h0} +: 8];
    end
  end

  // The power-on flag is set by reset and cleared by a status read.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      por_r <= 1'b1;
    end else if (rd_status) begin
      por_r <= 1'b0;
    end
  end

endmodule // tuner_serial_control_slave

// ### tb/tuner_serial_sva.sv
`timescale 1ns/1ps
// Watches the serial pins and the cap code of the control slave.
module tuner_serial_sva (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_link,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic i_addr_strap_high,
  input wire logic i_addr_strap_low,
  input wire logic [2:0] i_lock_indicator,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [5:0] o_parallel_cap_code
);
  logic scl_q; // Bus clock one link cycle ago.
  logic sda_q; // Bus data one link cycle ago.
  logic [4:0] bit_cnt_r; // Clock rises since the last start.
  logic [7:0] addr_r; // First byte after the last start.
  logic start_seen; // Data fell while the clock stayed high.
  logic scl_rise; // Bus clock went high.
  logic addr_ok; // First byte names this slave.
  logic [2:0] link_rst_q; // Reset as the link-clocked logic sees it.
  logic link_run; // Link-side logic has left reset.
  assign link_run = i_rst_n && link_rst_q[2];
  // Follows the slave's reset crossing into the link domain, plus margin.
  always_ff @(posedge i_clk_link) begin
    if (!i_rst_n) begin
      link_rst_q <= 3'h0;
    end else begin
      link_rst_q <= {link_rst_q[1:0], 1'b1};
    end
  end
  assign start_seen = i_scl && scl_q && sda_q && !i_sda_in;
  assign scl_rise = i_scl && !scl_q;
  assign addr_ok = addr_r[7:1] == {tuner_serial_pkg::SLAVE_ADDR_PREFIX,
                                   i_addr_strap_high, i_addr_strap_low};
  // Keeps the previous line levels for edge detection.
  always_ff @(posedge i_clk_link) begin
    scl_q <= i_scl;
    sda_q <= i_sda_in;
  end
  // Counts clock rises after a start and captures the address byte.
  always_ff @(posedge i_clk_link) begin
    if (!i_rst_n || start_seen) begin
      bit_cnt_r <= 5'h00;
    end else if (scl_rise && bit_cnt_r != 5'h1f) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
      if (bit_cnt_r < 5'h08) begin
        addr_r <= {addr_r[6:0], i_sda_in};
      end
    end
  end
  chk_out_always_low: assert property (@(posedge i_clk_link)
    disable iff (!link_run) o_sda_out == 1'b0)
    else $error("data pin driven high");
  chk_oe_steady_high: assert property (@(posedge i_clk_link)
    disable iff (!link_run) i_scl && scl_q |-> $stable(o_sda_oe))
    else $error("drive changed while clock high");
  chk_drive_starts_low: assert property (@(posedge i_clk_link)
    disable iff (!link_run) $rose(o_sda_oe) |-> !i_scl && !scl_q)
    else $error("drive began outside clock low");
  chk_release_clock_low: assert property (@(posedge i_clk_link)
    disable iff (!link_run) $fell(o_sda_oe) |-> !i_scl && !scl_q)
    else $error("release outside clock low");
  chk_stop_stays_off: assert property (@(posedge i_clk_link)
    disable iff (!link_run)
    i_scl && scl_q && !sda_q && i_sda_in |=> !o_sda_oe [*4])
    else $error("drive after stop");
  // The count moves at the first high sample, so a second one is awaited.
  chk_addr_silent: assert property (@(posedge i_clk_link)
    disable iff (!link_run)
    bit_cnt_r inside {[5'h01:5'h08]} && i_scl && scl_q |-> !o_sda_oe)
    else $error("drive during address byte");
  chk_addr_ack_match: assert property (@(posedge i_clk_link)
    disable iff (!link_run)
    bit_cnt_r == 5'h09 && i_scl && scl_q |-> o_sda_oe == addr_ok)
    else $error("address acknowledge wrong");
  chk_ptr_silent: assert property (@(posedge i_clk_link)
    disable iff (!link_run)
    bit_cnt_r inside {[5'h0a:5'h11]} && i_scl && scl_q && !addr_r[0]
    |-> !o_sda_oe) else $error("drive during written byte");
  chk_ptr_ack: assert property (@(posedge i_clk_link)
    disable iff (!link_run)
    bit_cnt_r == 5'h12 && i_scl && scl_q && addr_ok && !addr_r[0]
    |-> o_sda_oe) else $error("register byte not acknowledged");
  chk_code_reset: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n) $rose(i_rst_n) |-> o_parallel_cap_code == 6'h00)
    else $error("cap code not cleared by reset");
  // Main scenarios reached.
  cov_start: cover property (@(posedge i_clk_link) start_seen);
  cov_addr_ack: cover property (@(posedge i_clk_link)
    bit_cnt_r == 5'h09 && o_sda_oe);
  cov_code_change: cover property (@(posedge i_clk_sys)
    $changed(o_parallel_cap_code));
endmodule // tuner_serial_sva

// ### tb/serial_master_model.sv
`timescale 1ns/1ps
// Bus master that drives the clock and data lines by bit timing.
module serial_master_model #(
  parameter int T_LOW = 1400, // Clock low time in ns.
  parameter int T_HIGH = 1100 // Clock high time in ns; 400 kHz in all.
) (
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda_line
);
  // Both lines are released while the bus rests.
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Raises data with the clock low, then pulls it down under a high clock.
  task automatic bus_start();
    #(T_LOW / 2) o_sda = 1'b1;
    #(T_LOW / 2) o_scl = 1'b1;
    #(T_HIGH / 2) o_sda = 1'b0;
    #(T_HIGH / 2) o_scl = 1'b0;
  endtask
  // Lets data rise under a high clock and leaves the bus idle.
  task automatic bus_stop();
    #(T_LOW / 2) o_sda = 1'b0;
    #(T_LOW / 2) o_scl = 1'b1;
    #(T_HIGH / 2) o_sda = 1'b1;
    #(T_HIGH);
  endtask
  // One clock per bit; data changes only while the clock is low.
  task automatic put_bit(input logic b, output logic seen);
    #(T_LOW / 2) o_sda = b;
    #(T_LOW / 2) o_scl = 1'b1;
    #(T_HIGH / 2) seen = i_sda_line;
    #(T_HIGH / 2) o_scl = 1'b0;
  endtask
  // Sends a byte MSB first and releases data for the ninth clock.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], seen);
    end
    put_bit(1'b1, seen);
    ack = ~seen;
  endtask
  // Reads a byte MSB first and answers with ACK or NACK.
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, b[i]);
    end
    put_bit(nack, seen);
  endtask
endmodule // serial_master_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
// Drives the control slave through its serial bus and checks results.
module tb_top;
  localparam logic [127:0] ROM = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
  localparam int LIMIT = 95000; // Cycle ceiling for the whole run.
  logic clk_sys, clk_link, rst_n, strap_h, strap_l, scl, m_sda;
  logic sda_out, sda_oe, ack;
  logic [2:0] lock; // Lock level fed to the slave.
  logic [5:0] cap; // Cap code from the slave.
  logic [7:0] rd; // Last byte read.
  logic [7:0] addr_w; // Write form of the slave address.
  logic [2:0] locks [3] = '{3'h0, 3'h5, 3'h7};
  int mismatches, num_checks, cycles;
  wire sda_line = m_sda & ~sda_oe; // Pull-up wins unless someone pulls.
  assign addr_w = {tuner_serial_pkg::SLAVE_ADDR_PREFIX, strap_h, strap_l,
                   1'b0};
  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;
  // Link sampling clock, offset so its phase is unrelated.
  initial begin
    clk_link = 1'b0;
    #13;
    forever #32 clk_link = ~clk_link;
  end
  tuner_serial_control_slave #(.FACTORY_ROM(ROM)) dut_u (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_clk_link(clk_link),
    .i_scl(scl), .i_sda_in(sda_line), .i_addr_strap_high(strap_h),
    .i_addr_strap_low(strap_l), .i_lock_indicator(lock),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_parallel_cap_code(cap));
  serial_master_model master_u (.o_scl(scl), .o_sda(m_sda),
    .i_sda_line(sda_line));
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Counts one comparison and reports a failure.
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // Waits n clocks and lands just after the edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // Sends one byte and compares the acknowledge.
  task automatic send(input logic [7:0] b, input logic exp_ack);
    master_u.put_byte(b, ack);
    check(ack === exp_ack, "acknowledge");
  endtask
  // Writes one or two bytes from a register pointer on.
  task automatic write_regs(input logic [7:0] ptr, d0, d1, input int n);
    master_u.bus_start();
    send(addr_w, 1'b1);
    send(ptr, 1'b1);
    send(d0, 1'b1);
    if (n > 1) send(d1, 1'b1);
    master_u.bus_stop();
  endtask
  // Reads one or two bytes after a pointer write and a repeated start.
  task automatic read_regs(input logic [7:0] ptr, e0, e1, input int n);
    master_u.bus_start();
    send(addr_w, 1'b1);
    send(ptr, 1'b1);
    master_u.bus_start();
    send(addr_w | 8'h01, 1'b1);
    master_u.get_byte(n == 1, rd);
    check(rd === e0, "first read byte");
    if (n > 1) begin
      master_u.get_byte(1'b1, rd);
      check(rd === e1, "second read byte");
    end
    master_u.bus_stop();
  endtask
  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    {strap_h, strap_l} = 2'b00;
    lock = 3'h0;
    step(8);
    rst_n = 1'b1;
    check(cap === 6'h00, "cap code after reset");
    step(20);
    // Every strap setting: a foreign address is ignored, then a retry.
    for (int s = 0; s < 4; s++) begin
      {strap_h, strap_l} = s[1:0];
      step(20);
      master_u.bus_start();
      send(addr_w ^ 8'h02, 1'b0);
      send(addr_w, 1'b0);
      master_u.bus_start();
      send(addr_w, 1'b1);
      master_u.bus_stop();
    end
    // Status: power flag once, then the lock codes.
    for (int i = 0; i < 3; i++) begin
      lock = locks[i];
      step(10);
      read_regs(8'h0c, {i == 0, locks[i], 4'h0}, 8'h00, 1);
    end
    write_regs(8'h08, 8'h25, 8'h03, 2);
    check(cap === 6'h25, "cap code written");
    read_regs(8'h08, 8'h25, 8'h03, 2);
    write_regs(8'h08, 8'h85, 8'h00, 1);
    read_regs(8'h0b, ROM[8 * 3 +: 8], 8'h00, 1);
    write_regs(8'h09, 8'h0c, 8'h00, 1);
    write_regs(8'h08, 8'h85, 8'h00, 1);
    read_regs(8'h0b, ROM[8 * 3 +: 8], 8'h00, 1);
    write_regs(8'h08, 8'h05, 8'h00, 1);
    write_regs(8'h08, 8'h85, 8'h00, 1);
    read_regs(8'h0b, ROM[8 * 12 +: 8], 8'h00, 1);
    read_regs(8'h0a, 8'h00, 8'h00, 1);
    // A reset in mid-run clears the code and raises the power flag again.
    rst_n = 1'b0;
    step(8);
    rst_n = 1'b1;
    check(cap === 6'h00, "cap code after second reset");
    step(20);
    read_regs(8'h0c, {1'b1, locks[2], 4'h0}, 8'h00, 1);
    end_of_test();
  end
endmodule // tb_top
bind tuner_serial_control_slave tuner_serial_sva chk_u (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_link(i_clk_link),
  .i_scl(i_scl), .i_sda_in(i_sda_in),
  .i_addr_strap_high(i_addr_strap_high),
  .i_addr_strap_low(i_addr_strap_low),
  .i_lock_indicator(i_lock_indicator), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_parallel_cap_code(o_parallel_cap_code));
